// ==== shared/cml_consts.svh ====
// Summary of operation
// - Read lasts hi*256 plus low seven bits
// - Write lasts hi*256 plus low seven bits
// - Read length spans read strobe and select
// - Write length spans write strobe and select
// - Cycle length writes ignored while protected
// - Read length in bits 24:16, reset zero
// - Write length in bits 8:0, reset zero
`ifndef CML_CONSTS_SVH
`define CML_CONSTS_SVH

`define CML_NUM_CS 4
`define CML_LEN_W 9
`define CML_CNT_W 10
`define CML_HI_MULT 10'h100
`define CML_LEN_RST 9'h000

// Register byte offsets
`define CML_OFF_CYCLE_BASE 8'h00
`define CML_OFF_WPROT 8'h20
`define CML_OFF_STATUS 8'h24

// Field positions
`define CML_RD_LSB 16
`define CML_RD_MSB 24
`define CML_WR_LSB 0
`define CML_WR_MSB 8
`define CML_WRITE_PROTECT_ENABLE_BIT 0

`endif

// ==== shared/cml_pkg.sv ====
package cml_pkg;
   typedef enum logic [0:0] {
      CML_IDLE = 1'b0,
      CML_RUN = 1'b1
   } cml_state_t;
endpackage

// ==== rtl/cml_timer.sv ====
`timescale 1ns/1ps
`include "cml_consts.svh"

// Down counter for one access; o_last is high in the final cycle
module cml_timer (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_load,
   input wire logic [`CML_CNT_W-1:0] i_len,
   output logic o_last,
   output logic [`CML_CNT_W-1:0] o_cnt
);
   logic [`CML_CNT_W-1:0] cnt_q;
   logic [`CML_CNT_W-1:0] cnt_d;

   always_comb begin
      cnt_d = cnt_q;
      if (i_load) begin
         cnt_d = i_len;
      end else if (cnt_q != '0) begin
         cnt_d = cnt_q - `CML_CNT_W'(1);
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign o_last = (cnt_q == `CML_CNT_W'(1));
   assign o_cnt = cnt_q;
endmodule

// ==== rtl/cml_cycle_len.sv ====
`timescale 1ns/1ps
`include "cml_consts.svh"

module cml_cycle_len (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_acc_req,
   input wire logic [1:0] i_acc_cs,
   input wire logic i_acc_write,
   output logic o_acc_busy,
   output logic o_acc_done,
   output logic [`CML_NUM_CS-1:0] o_chip_select_n,
   output logic o_read_strobe_n,
   output logic o_write_strobe_n
);
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);

   // Total length from the 9-bit field; zero is stretched to one cycle
   function automatic logic [`CML_CNT_W-1:0] total_len(
      input logic [`CML_LEN_W-1:0] f);
      logic [`CML_CNT_W-1:0] t;
      t = `CML_CNT_W'(f[8:7]) * `CML_HI_MULT + `CML_CNT_W'(f[6:0]);
      if (t == '0) begin
         t = `CML_CNT_W'(1);
      end
      return t;
   endfunction

   // APB decode
   logic acc_phase;
   logic apb_take;
   logic hit_cycle;
   logic hit_wprot;
   logic hit_status;
   logic [1:0] reg_idx;
   assign acc_phase = i_psel && i_penable;
   assign apb_take = acc_phase && o_pready;
   assign reg_idx = i_paddr[3:2];
   assign hit_cycle = (i_paddr[7:4] == 4'(`CML_OFF_CYCLE_BASE >> 4))
                      && (i_paddr[1:0] == 2'h0);
   assign hit_wprot = (i_paddr == `CML_OFF_WPROT);
   assign hit_status = (i_paddr == `CML_OFF_STATUS);

   logic write_protect_enable_q;
   logic write_protect_enable_d;
   logic [`CML_LEN_W-1:0] rd_len_q [`CML_NUM_CS];
   logic [`CML_LEN_W-1:0] wr_len_q [`CML_NUM_CS];

   always_comb begin
      write_protect_enable_d = write_protect_enable_q;
      if (apb_take && i_pwrite && hit_wprot) begin
         write_protect_enable_d = i_pwdata[`CML_WRITE_PROTECT_ENABLE_BIT];
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         write_protect_enable_q <= 1'b0;
      end else begin
         write_protect_enable_q <= write_protect_enable_d;
      end
   end

   genvar g;
   generate
      for (g = 0; g < `CML_NUM_CS; g++) begin : g_cs
         logic [`CML_LEN_W-1:0] rd_d;
         logic [`CML_LEN_W-1:0] wr_d;
         always_comb begin
            rd_d = rd_len_q[g];
            wr_d = wr_len_q[g];
            if (apb_take && i_pwrite && hit_cycle && !write_protect_enable_q
                && (reg_idx == 2'(g))) begin
               rd_d = i_pwdata[`CML_RD_MSB:`CML_RD_LSB];
               wr_d = i_pwdata[`CML_WR_MSB:`CML_WR_LSB];
            end
         end
         always_ff @(posedge i_clock or posedge i_sys_rst) begin
            if (i_sys_rst) begin
               rd_len_q[g] <= `CML_LEN_RST;
               wr_len_q[g] <= `CML_LEN_RST;
            end else begin
               rd_len_q[g] <= rd_d;
               wr_len_q[g] <= wr_d;
            end
         end
      end
   endgenerate

   // Access sequencer
   cml_pkg::cml_state_t state_q;
   cml_pkg::cml_state_t state_d;
   logic [1:0] cs_q;
   logic [1:0] cs_d;
   logic dir_wr_q;
   logic dir_wr_d;
   logic [`CML_NUM_CS-1:0] csn_d;
   logic rdn_d;
   logic wrn_d;
   logic busy_d;
   logic done_d;
   logic accept;
   logic t_last;
   logic [`CML_CNT_W-1:0] t_cnt;
   logic [`CML_CNT_W-1:0] sel_len;

   assign accept = (state_q == cml_pkg::CML_IDLE) && i_acc_req;
   assign sel_len = i_acc_write ? total_len(wr_len_q[i_acc_cs])
                                : total_len(rd_len_q[i_acc_cs]);

   cml_timer u_timer (
      .i_clock(i_clock),
      .i_sys_rst(i_sys_rst),
      .i_load(accept),
      .i_len(sel_len),
      .o_last(t_last),
      .o_cnt(t_cnt)
   );

   always_comb begin
      state_d = state_q;
      cs_d = cs_q;
      dir_wr_d = dir_wr_q;
      csn_d = o_chip_select_n;
      rdn_d = o_read_strobe_n;
      wrn_d = o_write_strobe_n;
      busy_d = o_acc_busy;
      done_d = 1'b0;
      case (state_q)
         cml_pkg::CML_IDLE: begin
            if (accept) begin
               state_d = cml_pkg::CML_RUN;
               cs_d = i_acc_cs;
               dir_wr_d = i_acc_write;
               // Select and read strobe share the cycle
               // Select and write strobe share the cycle
               csn_d = ~(`CML_NUM_CS'(1) << i_acc_cs);
               rdn_d = i_acc_write;
               wrn_d = !i_acc_write;
               busy_d = 1'b1;
            end
         end
         cml_pkg::CML_RUN: begin
            // Release only when the length has run out
            if (t_last) begin
               state_d = cml_pkg::CML_IDLE;
               csn_d = '1;
               rdn_d = 1'b1;
               wrn_d = 1'b1;
               busy_d = 1'b0;
               done_d = 1'b1;
            end
         end
         default: begin
            state_d = cml_pkg::CML_IDLE;
            csn_d = '1;
            rdn_d = 1'b1;
            wrn_d = 1'b1;
            busy_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= cml_pkg::CML_IDLE;
         cs_q <= 2'h0;
         dir_wr_q <= 1'b0;
         o_chip_select_n <= '1;
         o_read_strobe_n <= 1'b1;
         o_write_strobe_n <= 1'b1;
         o_acc_busy <= 1'b0;
         o_acc_done <= 1'b0;
      end else begin
         state_q <= state_d;
         cs_q <= cs_d;
         dir_wr_q <= dir_wr_d;
         o_chip_select_n <= csn_d;
         o_read_strobe_n <= rdn_d;
         o_write_strobe_n <= wrn_d;
         o_acc_busy <= busy_d;
         o_acc_done <= done_d;
      end
   end

   // APB answer: one wait state, then a single ready cycle
   logic [31:0] prdata_d;
   logic pready_d;
   logic pslverr_d;

   always_comb begin
      prdata_d = o_prdata;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      if (acc_phase && !o_pready) begin
         pready_d = 1'b1;
         pslverr_d = !(hit_cycle || hit_wprot || hit_status);
         prdata_d = 32'h0;
         if (hit_cycle) begin
            prdata_d[`CML_RD_MSB:`CML_RD_LSB] = rd_len_q[reg_idx];
            prdata_d[`CML_WR_MSB:`CML_WR_LSB] = wr_len_q[reg_idx];
         end else if (hit_wprot) begin
            prdata_d[`CML_WRITE_PROTECT_ENABLE_BIT] = write_protect_enable_q;
         end else if (hit_status) begin
            prdata_d = {16'h0, 2'h0, t_cnt, dir_wr_q, cs_q, o_acc_busy};
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_prdata <= 32'h0;
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
      end else begin
         o_prdata <= prdata_d;
         o_pready <= pready_d;
         o_pslverr <= pslverr_d;
      end
   end

   // Helper: select-low cycle count and the length granted at accept
   logic [`CML_CNT_W-1:0] low_cnt_q;
   logic [`CML_CNT_W-1:0] granted_q;
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         low_cnt_q <= '0;
         granted_q <= '0;
      end else begin
         if (accept) begin
            granted_q <= sel_len;
         end
         if (o_chip_select_n == '1) begin
            low_cnt_q <= '0;
         end else begin
            low_cnt_q <= low_cnt_q + `CML_CNT_W'(1);
         end
      end
   end

   a_rd_total_len: assert property ($rose(o_read_strobe_n)
      |-> low_cnt_q == granted_q)
      else $error("Read strobe length differs from programmed total");
   a_wr_total_len: assert property ($rose(o_write_strobe_n)
      |-> low_cnt_q == granted_q)
      else $error("Write strobe length differs from programmed total");
   a_rd_cs_span: assert property ($fell(o_read_strobe_n)
      |-> $fell(o_chip_select_n[cs_q]))
      else $error("Read strobe and select do not start together");
   a_wr_cs_span: assert property (!o_write_strobe_n
      |-> o_chip_select_n[cs_q] == 1'b0)
      else $error("Write strobe active without its select");
   a_wp_blocks_write: assert property (
      apb_take && i_pwrite && hit_cycle && write_protect_enable_q
      |=> rd_len_q[$past(reg_idx)] == $past(rd_len_q[reg_idx])
          && wr_len_q[$past(reg_idx)] == $past(wr_len_q[reg_idx]))
      else $error("Cycle length changed while protected");
   a_rd_field_write: assert property (
      apb_take && i_pwrite && hit_cycle && !write_protect_enable_q
      |=> rd_len_q[$past(reg_idx)]
          == $past(i_pwdata[`CML_RD_MSB:`CML_RD_LSB]))
      else $error("Read length field not stored");
   a_wr_field_write: assert property (
      apb_take && i_pwrite && hit_cycle && !write_protect_enable_q
      |=> wr_len_q[$past(reg_idx)]
          == $past(i_pwdata[`CML_WR_MSB:`CML_WR_LSB]))
      else $error("Write length field not stored");
   a_no_early_start: assert property (o_acc_busy && !t_last
      |=> o_acc_busy && $stable(o_chip_select_n))
      else $error("New access started before length elapsed");
   a_apb_ready: assert property (acc_phase && !o_pready
      |=> o_pready ##1 !o_pready)
      else $error("APB ready not a single cycle after one wait");

   c_read_access: cover property (
      $rose(o_read_strobe_n) && granted_q > `CML_CNT_W'(2));
   c_write_access: cover property ($rose(o_write_strobe_n));
   c_wp_reject: cover property (apb_take && i_pwrite && hit_cycle && write_protect_enable_q);
   c_back_to_back: cover property (o_acc_done ##1 o_acc_busy);
endmodule

// ==== testbench/cml_mem_model.sv ====
`timescale 1ns/1ps

// Far-side memory; measures each select window it sees
module cml_mem_model (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_chip_select_n,
   input wire logic i_read_strobe_n,
   input wire logic i_write_strobe_n,
   output logic [9:0] o_len,
   output logic [3:0] o_sel_n,
   output logic o_wr,
   output logic o_bad,
   output logic [7:0] o_num
);
   logic [9:0] cnt_q;
   logic on;
   assign on = (i_chip_select_n != 4'hf);
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         cnt_q <= '0;
         o_len <= '0;
         o_sel_n <= 4'hf;
         o_wr <= 1'b0;
         o_bad <= 1'b0;
         o_num <= '0;
      end else if (on) begin
         cnt_q <= cnt_q + 10'h001;
         o_sel_n <= i_chip_select_n;
         o_wr <= ~i_write_strobe_n;
         if ((i_read_strobe_n ^ i_write_strobe_n) != 1'b1) o_bad <= 1'b1;
         if (cnt_q != 0 && i_chip_select_n != o_sel_n) o_bad <= 1'b1;
      end else begin
         if (!(i_read_strobe_n && i_write_strobe_n)) o_bad <= 1'b1;
         if (cnt_q != 0) begin
            o_len <= cnt_q;
            o_num <= o_num + 8'h01;
         end
         cnt_q <= '0;
      end
   end
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps

module testbench;
   logic i_clock, i_sys_rst, psel, pen, pwr, pready, perr, req, wr;
   logic busy, done, rd_n, wr_n, bad, mwr, err;
   logic [7:0] paddr, num;
   logic [31:0] pwdata, prdata, rd;
   logic [1:0] cs;
   logic [3:0] cs_n, sel_n;
   logic [9:0] len;
   int error_cnt, cmp_count;

   cml_cycle_len uut (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(perr), .i_acc_req(req), .i_acc_cs(cs),
      .i_acc_write(wr), .o_acc_busy(busy), .o_acc_done(done),
      .o_chip_select_n(cs_n), .o_read_strobe_n(rd_n),
      .o_write_strobe_n(wr_n));
   cml_mem_model mem (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_chip_select_n(cs_n), .i_read_strobe_n(rd_n),
      .i_write_strobe_n(wr_n), .o_len(len), .o_sel_n(sel_n),
      .o_wr(mwr), .o_bad(bad), .o_num(num));

   initial begin
      i_clock = 1'b0;
      forever #2 i_clock = ~i_clock;
   end

   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clock);
      pen <= 1'b1;
      do begin
         @(posedge i_clock);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk(32'h1, 32'h0);
      rd = prdata;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge i_clock);
   endtask

   // Poke keeps asking with another select while busy
   task automatic acc(input logic [1:0] c, input logic w,
                      input logic [9:0] l, input logic poke);
      int n;
      logic [7:0] n0;
      n = 0;
      n0 = num;
      req <= 1'b1;
      cs <= c;
      wr <= w;
      do begin
         @(posedge i_clock);
         n++;
      end while (busy !== 1'b1 && n < 9);
      if (poke) begin
         cs <= c + 2'd1;
         repeat (l - 1) @(posedge i_clock);
      end
      req <= 1'b0;
      do begin
         @(posedge i_clock);
         n++;
      end while (done !== 1'b1 && n < 1000);
      @(posedge i_clock);
      chk(32'(len), 32'(l));
      chk(32'(sel_n), {28'h0, ~(4'h1 << c)});
      chk(32'(mwr), 32'(w));
      chk(32'(num), {24'h0, n0 + 8'h01});
   endtask

   function automatic logic [9:0] exp_len(input logic [8:0] f);
      logic [9:0] l;
      l = {f[8:7], 8'h00} + {3'b000, f[6:0]};
      if (l == 10'h000) l = 10'h001;
      return l;
   endfunction

   initial begin
      logic [8:0] rf, wf, w0;
      logic [31:0] v, k0;
      i_sys_rst = 1'b1;
      {psel, pen, pwr, req, wr} = '0;
      paddr = '0;
      pwdata = '0;
      cs = '0;
      void'($urandom(32'h22cd));
      repeat (2) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      for (int k = 0; k < 5; k++) begin
         apb(1'b0, (k < 4) ? 8'(k * 4) : 8'h20, 32'h0);
         chk(rd, 32'h0);
      end
      apb(1'b1, 8'h40, 32'hffffffff);
      chk(32'(err), 32'h1);
      $display("test reset and unmapped done");
      for (int c = 0; c < 4; c++) begin
         rf = (c == 0) ? 9'h000 : (c == 1) ? 9'h17f : 9'($urandom);
         wf = (c == 2) ? 9'h080 : (c == 3) ? 9'h001 : 9'($urandom);
         v = {7'h0, rf, 7'h0, wf} | ($urandom & 32'hfe00fe00);
         apb(1'b1, 8'(c * 4), v);
         apb(1'b0, 8'(c * 4), 32'h0);
         chk(rd, v & 32'h01ff01ff);
         if (c == 0) k0 = rd;
         if (c == 0) w0 = wf;
         acc(2'(c), 1'b0, exp_len(rf), c[0]);
         acc(2'(c), 1'b1, exp_len(wf), c[1]);
      end
      $display("test lengths done");
      apb(1'b1, 8'h20, 32'h1);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h1);
      apb(1'b1, 8'h00, 32'h00050005);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, k0);
      acc(2'd0, 1'b1, exp_len(w0), 1'b0);
      // Idle status: select 0, write direction, nothing left to count
      apb(1'b0, 8'h24, 32'h0);
      chk(rd, 32'h8);
      apb(1'b1, 8'h20, 32'h0);
      apb(1'b1, 8'h00, 32'h00050005);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h00050005);
      acc(2'd0, 1'b0, 10'h005, 1'b1);
      chk(32'(bad), 32'h0);
      $display("test protect done");
      // Reset in mid-run must clear lengths and protection again
      apb(1'b1, 8'h20, 32'h1);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk(rd, 32'h0);
      $display("test mid-run reset done");
      results();
   end

   initial begin
      #(4 * 40000);
      error_cnt++;
      results();
   end
endmodule
